// file: src/bscm_pkg.sv
// Purpose: shared constants and types for boot strap capture and address map
// Assumes: 32-bit byte addresses, AXI4-Lite register access
// Notes: region table is ordered; the first match wins
package bscm_pkg;

    // boot vector of the only hardware boot path
    localparam logic [31:0] BOOT_VECTOR = 32'h0000_0000;

    // register byte addresses
    localparam logic [31:0] CAP_LOW_ADDR = 32'h4000_0000;
    localparam logic [31:0] CAP_HIGH_ADDR = 32'h4000_0004;
    localparam logic [31:0] CHECK_CTRL_ADDR = 32'h4000_0078;
    localparam logic [31:0] VIOL_STATUS_ADDR = 32'h4000_007c;
    localparam logic [31:0] VIOL_ADDR_ADDR = 32'h4000_0080;

    // field positions and reset values
    localparam int CAP_WIDTH = 8;
    localparam int CHECK_EN_BIT = 0;
    localparam int VIOL_FLAG_BIT = 0;
    localparam logic CHECK_EN_RST = 1'h1;
    localparam logic [7:0] CAP_RST = 8'h00;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // access sizes of the map checker
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // sdram configuration register: only its top byte takes byte writes
    localparam logic [31:0] SDRAM_CFG_TOP_BYTE = 32'hf000_000b;

    // address map
    localparam int NUM_REGIONS = 27;
    localparam logic [4:0] RGN_NONE = 5'h1f;
    localparam logic [4:0] RGN_EMU = 5'h04;
    localparam logic [31:0] REGION_BASE [0:26] = '{
        32'h0000_0000, 32'h0004_0000, 32'h1000_0000, 32'h2000_0000,
        32'h3000_0000, 32'h4000_0000, 32'h4100_0000, 32'h4200_0000,
        32'h4300_0000, 32'h4400_0000, 32'h4500_0000, 32'h4600_0000,
        32'h4700_0000, 32'h4800_0000, 32'h4900_0000, 32'h4a00_0000,
        32'h5400_0000, 32'h5500_0000, 32'h5600_0000, 32'h6000_0000,
        32'h6100_8000, 32'h6100_80a0, 32'h6200_8000, 32'h6200_80a0,
        32'h8000_0000, 32'h9000_0000, 32'hf000_0000};
    localparam logic [31:0] REGION_END [0:26] = '{
        32'h0003_ffff, 32'h0005_ffff, 32'h1003_ffff, 32'h2000_001f,
        32'h3fff_ffff, 32'h4000_0083, 32'h4100_015f, 32'h4200_00a3,
        32'h4300_0043, 32'h4400_02bf, 32'h4500_02bf, 32'h4600_02bf,
        32'h4700_007f, 32'h4800_007f, 32'h4900_007f, 32'h4a00_007f,
        32'h54ff_ffff, 32'h55ff_ffff, 32'h56ff_ffff, 32'h6000_008f,
        32'h6100_807f, 32'h6100_81ff, 32'h6200_807f, 32'h6200_81ff,
        32'h8fff_ffff, 32'h9fff_ffff, 32'hf000_00bf};
    // bit i set: region i takes byte and word accesses
    localparam logic [26:0] REGION_BYTE = 27'h3f0_0007;

    typedef enum logic [2:0] {
        AX_IDLE = 3'b001,
        AX_WRESP = 3'b010,
        AX_RRESP = 3'b100
    } bscm_axi_t;

    typedef struct packed {
        logic ext_prev;
        logic [7:0] cap_low;
        logic [7:0] cap_high;
        logic host_boot;
        logic [2:0] host_cfg;
        logic rst_req;
        logic [31:0] fetch_addr;
        logic chk_en;
        logic viol_flag;
        logic [31:0] viol_addr;
        bscm_axi_t st;
        logic aw_got;
        logic w_got;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
        logic [1:0] resp;
    } bscm_state_t;

    typedef struct packed {
        logic valid;
        logic [4:0] region;
        logic permit;
        logic forbidden;
        logic bad_width;
        logic [31:0] addr;
    } bscm_dec_state_t;

    function automatic logic [4:0] region_of(input logic [31:0] addr);
        logic [4:0] r;
        r = RGN_NONE;
        for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
            if (addr >= REGION_BASE[i] && addr <= REGION_END[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic aligned(input logic [31:0] addr, input logic [1:0] size);
        logic ok;
        ok = (size == SIZE_BYTE) || (size == SIZE_HALF && !addr[0]) ||
             (size == SIZE_WORD && addr[1:0] == 2'h0);
        return ok;
    endfunction

endpackage

// file: src/bscm_map_decode.sv
// Purpose: address map decoder and access checker for on-chip masters
// Assumes: one request per cycle, answer one cycle later from flops
// Notes: forbidden covers the emulation window, gaps and unmapped space
`timescale 1ns/1ps
module bscm_map_decode (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // request
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic req_write,
    input wire logic check_en,
    // answer
    output logic rsp_valid,
    output logic [4:0] rsp_region,
    output logic rsp_permit,
    output logic rsp_forbidden,
    output logic rsp_bad_width
);
    bscm_pkg::bscm_dec_state_t q;
    bscm_pkg::bscm_dec_state_t next_q;
    logic [4:0] rgn;
    logic byte_ok;
    logic width_ok;
    logic sdram_top;

    always_comb begin
        next_q = q;
        // rom pages, ram, data windows, dma tables and external spaces
        rgn = bscm_pkg::region_of(req_addr);
        byte_ok = (rgn != bscm_pkg::RGN_NONE) && bscm_pkg::REGION_BYTE[rgn];
        // top byte of sdram config takes byte writes
        sdram_top = req_write && req_size == bscm_pkg::SIZE_BYTE &&
                    req_addr == bscm_pkg::SDRAM_CFG_TOP_BYTE;
        // control regions word only
        width_ok = bscm_pkg::aligned(req_addr, req_size) &&
                   (byte_ok || req_size == bscm_pkg::SIZE_WORD || sdram_top);
        next_q.valid = req_valid;
        next_q.region = rgn;
        next_q.addr = req_addr;
        // emulation window and unmapped space never reach a target
        next_q.forbidden = (rgn == bscm_pkg::RGN_NONE) || (rgn == bscm_pkg::RGN_EMU);
        next_q.bad_width = !width_ok;
        next_q.permit = !next_q.forbidden && (width_ok || !check_en);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign rsp_valid = q.valid;
    assign rsp_region = q.region;
    assign rsp_permit = q.permit;
    assign rsp_forbidden = q.forbidden;
    assign rsp_bad_width = q.bad_width;

    AST_EMU_DENY: assert property (@(posedge core_clk) disable iff (!nrst)
        req_valid && req_addr[31:28] == 4'h3 |=> rsp_valid && !rsp_permit && rsp_forbidden)
        else $error("emulation window access permitted");

    AST_WORD_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
        req_valid && check_en && req_size == bscm_pkg::SIZE_BYTE &&
        req_addr[31:28] == 4'h4 |=> !rsp_permit && rsp_bad_width)
        else $error("byte access to word-only region permitted");

    AST_ROM_BYTE: assert property (@(posedge core_clk) disable iff (!nrst)
        req_valid && req_size == bscm_pkg::SIZE_BYTE && req_addr < 32'h0006_0000
        |=> rsp_permit && rsp_region <= 5'h01)
        else $error("rom byte access refused");
endmodule

// file: src/bscm_top.sv
// Purpose: boot strap capture, boot vector and address map checker
// Assumes: all pin inputs synchronous to core_clk; ext_reset_n active low
// Notes: registers over axi4-lite; write answer two cycles after the last
//        of address and data, read answer one cycle after the address
`timescale 1ns/1ps
module bscm_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // reset sources
    input wire logic ext_reset_n,
    input wire logic emu_reset_req,
    input wire logic rti_reset_req,
    // strap pins
    input wire logic serial0_data_in_pin,
    input wire logic serial0_data_out_pin,
    input wire logic serial0_clock_pin,
    input wire logic serial0_chip_sel_pin,
    input wire logic serial0_enable_pin,
    input wire logic serial1_data_in_pin,
    input wire logic serial1_data_out_pin,
    input wire logic serial1_clock_pin,
    input wire logic serial1_chip_sel_pin,
    input wire logic serial1_enable_pin,
    input wire logic host_port_chip_select,
    input wire logic host_data0_pin,
    input wire logic host_addr0_pin,
    input wire logic asp_tx_fsync_pin,
    input wire logic asp_rx_fsync_pin,
    input wire logic asp_serializer0_pin,
    // boot outputs
    output logic core_reset_req,
    output logic [31:0] boot_fetch_addr,
    output logic host_boot_sel,
    output logic host_byte_addressing,
    output logic host_full_width,
    output logic host_non_multiplexed,
    // map check port
    input wire logic map_req_valid,
    input wire logic [31:0] map_req_addr,
    input wire logic [1:0] map_req_size,
    input wire logic map_req_write,
    output logic map_rsp_valid,
    output logic [4:0] map_rsp_region,
    output logic map_rsp_permit,
    output logic map_rsp_forbidden,
    output logic map_rsp_bad_width,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    bscm_pkg::bscm_state_t q;
    bscm_pkg::bscm_state_t next_q;
    logic ext_rise;
    logic idle;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [7:0] pins_low;
    logic [7:0] pins_high;
    logic [31:0] map_addr_held;

    assign pins_low = {serial0_data_in_pin, serial0_data_out_pin, serial0_clock_pin,
                       serial0_chip_sel_pin, serial0_enable_pin, serial1_data_in_pin,
                       serial1_data_out_pin, serial1_clock_pin};
    assign pins_high = {serial1_chip_sel_pin, serial1_enable_pin, host_port_chip_select,
                        host_data0_pin, host_addr0_pin, asp_tx_fsync_pin,
                        asp_rx_fsync_pin, asp_serializer0_pin};

    assign idle = (q.st == bscm_pkg::AX_IDLE);
    // reads win when nothing of a write is held yet
    assign s_axi_arready = idle && !q.aw_got && !q.w_got;
    assign s_axi_awready = idle && !q.aw_got && !(s_axi_arvalid && !q.w_got);
    assign s_axi_wready = idle && !q.w_got && !(s_axi_arvalid && !q.aw_got);
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign ext_rise = ext_reset_n && !q.ext_prev;

    function automatic logic [31:0] read_word(input bscm_pkg::bscm_state_t s,
                                              input logic [31:0] addr);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            // reserved upper bits read as zero
            bscm_pkg::CAP_LOW_ADDR: v[bscm_pkg::CAP_WIDTH-1:0] = s.cap_low;
            bscm_pkg::CAP_HIGH_ADDR: v[bscm_pkg::CAP_WIDTH-1:0] = s.cap_high;
            bscm_pkg::CHECK_CTRL_ADDR: v[bscm_pkg::CHECK_EN_BIT] = s.chk_en;
            bscm_pkg::VIOL_STATUS_ADDR: v[bscm_pkg::VIOL_FLAG_BIT] = s.viol_flag;
            bscm_pkg::VIOL_ADDR_ADDR: v = s.viol_addr;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        logic m;
        m = (addr == bscm_pkg::CAP_LOW_ADDR) || (addr == bscm_pkg::CAP_HIGH_ADDR) ||
            (addr == bscm_pkg::CHECK_CTRL_ADDR) || (addr == bscm_pkg::VIOL_STATUS_ADDR) ||
            (addr == bscm_pkg::VIOL_ADDR_ADDR);
        return m;
    endfunction

    always_comb begin
        next_q = q;
        next_q.ext_prev = ext_reset_n;
        // only the external reset release resamples the straps
        if (ext_rise) begin
            next_q.cap_low = pins_low;
            next_q.cap_high = pins_high;
            next_q.host_boot = !host_port_chip_select;
            // host boot: serial0 levels become host port configuration
            if (!host_port_chip_select) begin
                next_q.host_cfg = {serial0_data_in_pin, serial0_data_out_pin,
                                   serial0_clock_pin};
            end
        end
        // any reset source restarts the core at the rom boot vector
        next_q.rst_req = !ext_reset_n || emu_reset_req || rti_reset_req;
        if (next_q.rst_req) begin
            next_q.fetch_addr = bscm_pkg::BOOT_VECTOR;
        end

        // map violation logging; a new event wins over a clear
        if (q.st == bscm_pkg::AX_IDLE && q.aw_got && q.w_got &&
            q.waddr == bscm_pkg::VIOL_STATUS_ADDR && q.wstrb[0] &&
            q.wdata[bscm_pkg::VIOL_FLAG_BIT]) begin
            next_q.viol_flag = 1'b0;
        end
        if (map_rsp_valid && !map_rsp_permit) begin
            next_q.viol_flag = 1'b1;
            next_q.viol_addr = map_addr_held;
        end

        case (q.st)
            bscm_pkg::AX_IDLE: begin
                if (aw_hs) begin
                    next_q.aw_got = 1'b1;
                    next_q.waddr = s_axi_awaddr;
                end
                if (w_hs) begin
                    next_q.w_got = 1'b1;
                    next_q.wdata = s_axi_wdata;
                    next_q.wstrb = s_axi_wstrb;
                end
                if (q.aw_got && q.w_got) begin
                    // read-only targets accept and ignore writes; unmapped addresses answer decerr
                    next_q.resp = mapped(q.waddr) ? bscm_pkg::RESP_OKAY
                                                  : bscm_pkg::RESP_DECERR;
                    if (q.waddr == bscm_pkg::CHECK_CTRL_ADDR && q.wstrb[0]) begin
                        next_q.chk_en = q.wdata[bscm_pkg::CHECK_EN_BIT];
                    end
                    next_q.st = bscm_pkg::AX_WRESP;
                end else if (ar_hs) begin
                    next_q.rdata = read_word(q, s_axi_araddr);
                    next_q.resp = mapped(s_axi_araddr) ? bscm_pkg::RESP_OKAY
                                                       : bscm_pkg::RESP_DECERR;
                    next_q.st = bscm_pkg::AX_RRESP;
                end
            end
            bscm_pkg::AX_WRESP: begin
                if (s_axi_bready) begin
                    next_q.aw_got = 1'b0;
                    next_q.w_got = 1'b0;
                    next_q.st = bscm_pkg::AX_IDLE;
                end
            end
            bscm_pkg::AX_RRESP: begin
                if (s_axi_rready) begin
                    next_q.st = bscm_pkg::AX_IDLE;
                end
            end
            default: begin
                next_q.st = bscm_pkg::AX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{ext_prev: 1'b0, cap_low: bscm_pkg::CAP_RST, cap_high: bscm_pkg::CAP_RST,
                   host_boot: 1'b0, host_cfg: 3'h0, rst_req: 1'b1,
                   fetch_addr: bscm_pkg::BOOT_VECTOR, chk_en: bscm_pkg::CHECK_EN_RST,
                   viol_flag: 1'b0, viol_addr: 32'h0000_0000, st: bscm_pkg::AX_IDLE,
                   aw_got: 1'b0, w_got: 1'b0, waddr: 32'h0000_0000,
                   wdata: 32'h0000_0000, wstrb: 4'h0, rdata: 32'h0000_0000,
                   resp: bscm_pkg::RESP_OKAY};
        end else begin
            q <= next_q;
        end
    end

    // address of the request being answered by the decoder
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            map_addr_held <= 32'h0000_0000;
        end else begin
            map_addr_held <= map_req_addr;
        end
    end

    bscm_map_decode u_decode (
        .core_clk(core_clk),
        .nrst(nrst),
        .req_valid(map_req_valid),
        .req_addr(map_req_addr),
        .req_size(map_req_size),
        .req_write(map_req_write),
        .check_en(q.chk_en),
        .rsp_valid(map_rsp_valid),
        .rsp_region(map_rsp_region),
        .rsp_permit(map_rsp_permit),
        .rsp_forbidden(map_rsp_forbidden),
        .rsp_bad_width(map_rsp_bad_width)
    );

    assign core_reset_req = q.rst_req;
    assign boot_fetch_addr = q.fetch_addr;
    assign host_boot_sel = q.host_boot;
    assign host_byte_addressing = q.host_cfg[2];
    assign host_full_width = q.host_cfg[1];
    assign host_non_multiplexed = q.host_cfg[0];
    assign s_axi_bvalid = (q.st == bscm_pkg::AX_WRESP);
    assign s_axi_bresp = q.resp;
    assign s_axi_rvalid = (q.st == bscm_pkg::AX_RRESP);
    assign s_axi_rresp = q.resp;
    assign s_axi_rdata = q.rdata;

    AST_BOOT_VECTOR: assert property (@(posedge core_clk) disable iff (!nrst)
        (emu_reset_req || rti_reset_req) |=> core_reset_req && boot_fetch_addr == 32'h0)
        else $error("reset did not restart at boot vector");

    AST_CAPTURE_LOW: assert property (@(posedge core_clk) disable iff (!nrst)
        ext_reset_n && !$past(ext_reset_n) |=> q.cap_low == $past(pins_low))
        else $error("low capture does not match straps");

    AST_CAPTURE_HIGH: assert property (@(posedge core_clk) disable iff (!nrst)
        ext_reset_n && !$past(ext_reset_n) |=> q.cap_high[5] == $past(host_port_chip_select)
        && q.cap_high[0] == $past(asp_serializer0_pin))
        else $error("high capture does not match straps");

    AST_CAPTURE_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
        !(ext_reset_n && !q.ext_prev) |=> $stable(q.cap_low) && $stable(q.cap_high))
        else $error("capture changed without external reset release");

    AST_CAPTURE_EDGE: assert property (@(posedge core_clk) disable iff (!nrst)
        !ext_reset_n ##1 ext_reset_n ##1 ext_reset_n [*2] |-> $stable(q.cap_low))
        else $error("capture not held after release");

    AST_HOST_CFG: assert property (@(posedge core_clk) disable iff (!nrst)
        ext_rise && !host_port_chip_select |=> host_boot_sel &&
        host_byte_addressing == $past(serial0_data_in_pin) &&
        host_non_multiplexed == $past(serial0_clock_pin))
        else $error("host config not copied from straps");

    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        ar_hs && s_axi_araddr == bscm_pkg::CAP_LOW_ADDR |=> s_axi_rvalid &&
        s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0)
        else $error("capture read malformed");

    AST_UNMAPPED_ANSWER: assert property (@(posedge core_clk) disable iff (!nrst)
        aw_hs && w_hs && !mapped(s_axi_awaddr) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h3)
        else $error("unmapped write not answered in time");

    AST_CTRL_STEERS: assert property (@(posedge core_clk) disable iff (!nrst)
        !q.chk_en && map_req_valid && map_req_addr[31:8] == 24'h4a_0000 &&
        !map_req_addr[7] |=> map_rsp_permit)
        else $error("disabled checker still refuses");
endmodule

// file: sim/bscm_strap_model.sv
// Purpose: board strap model that sets the boot pin levels
// Assumes: straps are static levels chosen by the bench
// Notes: bit 15 is serial0 data in, bit 5 host select, bit 0 serializer0
`timescale 1ns/1ps
module bscm_strap_model (
    // board setting
    input wire logic [15:0] strap_word,
    // strap pin levels
    output logic [15:0] strap_pins
);
    // host select low picks host boot, and then serial0 levels pick the host port mode
    assign strap_pins = strap_word;
endmodule

// file: sim/bscm_top_bench.sv
// Purpose: self-checking bench for strap capture, boot vector and map checker
// Assumes: registers over axi4-lite, straps from the board model
// Notes: region indices follow the package table order
`timescale 1ns/1ps
module bscm_top_bench;
    logic core_clk, nrst, ext_reset_n, emu_reset_req, rti_reset_req, map_req_valid;
    logic map_req_write, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] map_req_addr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, boot_fetch_addr, s_axi_rdata;
    logic [1:0] map_req_size, s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0] s_axi_wstrb;
    logic [15:0] strap_word;
    wire logic [15:0] strap_pins;
    logic core_reset_req, host_boot_sel, host_byte_addressing, host_full_width;
    logic host_non_multiplexed, map_rsp_valid, map_rsp_permit, map_rsp_forbidden;
    logic map_rsp_bad_width, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0] map_rsp_region;
    logic [31:0] rd;
    int err_count, samples_checked;
    bscm_strap_model i_straps (.strap_word(strap_word), .strap_pins(strap_pins));
    bscm_top i_dut (
        .*,
        .serial0_data_in_pin(strap_pins[15]), .serial0_data_out_pin(strap_pins[14]),
        .serial0_clock_pin(strap_pins[13]), .serial0_chip_sel_pin(strap_pins[12]),
        .serial0_enable_pin(strap_pins[11]), .serial1_data_in_pin(strap_pins[10]),
        .serial1_data_out_pin(strap_pins[9]), .serial1_clock_pin(strap_pins[8]),
        .serial1_chip_sel_pin(strap_pins[7]), .serial1_enable_pin(strap_pins[6]),
        .host_port_chip_select(strap_pins[5]), .host_data0_pin(strap_pins[4]),
        .host_addr0_pin(strap_pins[3]), .asp_tx_fsync_pin(strap_pins[2]),
        .asp_rx_fsync_pin(strap_pins[1]), .asp_serializer0_pin(strap_pins[0])
    );
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            err_count++;
            $display("unexpected at %0t: bus timeout", $time);
            test_done();
        end
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n);
    endtask
    task automatic axr(input logic [31:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tmo(n);
    endtask
    task automatic caps(input logic [15:0] p);
        axr(bscm_pkg::CAP_LOW_ADDR);
        chk({rsp, rd}, {bscm_pkg::RESP_OKAY, 24'h0, p[15:8]});
        axr(bscm_pkg::CAP_HIGH_ADDR);
        chk({rsp, rd}, {bscm_pkg::RESP_OKAY, 24'h0, p[7:0]});
    endtask
    // hold the external reset low, then release it with new straps
    task automatic strap(input logic [15:0] p);
        strap_word <= p;
        ext_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        ext_reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    // size: 0 byte, 1 half, 2 word
    task automatic mq(input logic [31:0] a, input logic [1:0] s, input logic w,
                      input logic [4:0] r, input logic p, input logic f);
        map_req_addr <= a;
        map_req_size <= s;
        map_req_write <= w;
        map_req_valid <= 1'b1;
        @(posedge core_clk);
        map_req_valid <= 1'b0;
        #1;
        chk({map_rsp_valid, map_rsp_region, map_rsp_permit, map_rsp_forbidden}, {1'b1, r, p, f});
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {nrst, ext_reset_n, emu_reset_req, rti_reset_req, map_req_valid, map_req_write} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {map_req_addr, s_axi_awaddr, s_axi_wdata, s_axi_araddr, map_req_size} = '0;
        s_axi_wstrb = 4'hf;
        strap_word = 16'hb3c6;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        strap(16'hb3c6);
        chk(boot_fetch_addr, 32'h0);
        caps(16'hb3c6);
        chk({host_boot_sel, host_byte_addressing, host_full_width, host_non_multiplexed}, 4'hd);
        strap_word <= 16'h4c3d;
        emu_reset_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(core_reset_req, 1'b1);
        emu_reset_req <= 1'b0;
        rti_reset_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        rti_reset_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        caps(16'hb3c6);
        axw(bscm_pkg::CAP_LOW_ADDR, 32'h0);
        chk(rsp, bscm_pkg::RESP_OKAY);
        caps(16'hb3c6);
        strap(16'h4c3d);
        caps(16'h4c3d);
        chk({host_boot_sel, host_byte_addressing, host_full_width, host_non_multiplexed}, 4'h5);
        axr(32'h4000_0010);
        chk({rsp, rd}, {bscm_pkg::RESP_DECERR, 32'h0});
        axw(32'h4000_0010, 32'h0);
        chk(rsp, bscm_pkg::RESP_DECERR);
        mq(32'h0000_0001, 2'h0, 1'b0, 5'h00, 1'b1, 1'b0);
        mq(32'h0005_fffe, 2'h1, 1'b1, 5'h01, 1'b1, 1'b0);
        mq(32'h1003_fffc, 2'h2, 1'b1, 5'h02, 1'b1, 1'b0);
        mq(32'h0006_0000, 2'h2, 1'b0, 5'h1f, 1'b0, 1'b1);
        mq(32'h2000_001c, 2'h2, 1'b1, 5'h03, 1'b1, 1'b0);
        mq(32'h2000_0020, 2'h2, 1'b0, 5'h1f, 1'b0, 1'b1);
        mq(32'h3000_0000, 2'h2, 1'b0, 5'h04, 1'b0, 1'b1);
        mq(32'h4a00_0003, 2'h0, 1'b1, 5'h0f, 1'b0, 1'b0);
        chk(map_rsp_bad_width, 1'b1);
        mq(32'h54ff_fffc, 2'h2, 1'b1, 5'h10, 1'b1, 1'b0);
        mq(32'h9fff_ffff, 2'h0, 1'b0, 5'h19, 1'b1, 1'b0);
        mq(32'h8000_0002, 2'h1, 1'b1, 5'h18, 1'b1, 1'b0);
        mq(32'hf000_000b, 2'h0, 1'b1, 5'h1a, 1'b1, 1'b0);
        chk(map_rsp_bad_width, 1'b0);
        mq(32'hf000_0008, 2'h0, 1'b1, 5'h1a, 1'b0, 1'b0);
        mq(32'h6100_8080, 2'h2, 1'b0, 5'h1f, 1'b0, 1'b1);
        mq(32'h6200_80a1, 2'h0, 1'b1, 5'h17, 1'b1, 1'b0);
        axr(bscm_pkg::VIOL_ADDR_ADDR);
        chk({rsp, rd}, {bscm_pkg::RESP_OKAY, 32'h6100_8080});
        axr(bscm_pkg::VIOL_STATUS_ADDR);
        chk({rsp, rd}, {bscm_pkg::RESP_OKAY, 32'h1});
        axw(bscm_pkg::CHECK_CTRL_ADDR, 32'h0);
        mq(32'h4a00_0003, 2'h0, 1'b1, 5'h0f, 1'b1, 1'b0);
        chk(map_rsp_bad_width, 1'b1);
        test_done();
    end
endmodule
